// *** hdl/tsc_top.v ***
// temperature sensor enable control: two registers over classic wishbone
// assumes a classic wishbone master on clk_i; analog parts sit outside
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
`include "tsc_consts.vh"
module tsc_top #(
	parameter SETTLE_CYC     = `TSC_SETTLE_CYC,
	parameter REF_SETTLE_CYC = `TSC_REF_SETTLE_CYC
) (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [3:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	output reg         bandgap_on_o,
	output reg         amplifier_on_o,
	output reg         sensor_on_o,
	output reg         sensor_valid_o,
	output reg         ref_settled_o,
	output reg  [2:0]  adc_channel_o
);
	// ----------------------------------------
	// constants at their widths
	// ----------------------------------------
	localparam [1:0]   RST_REF  = `TSC_RST_REF_AMP_EN;
	localparam [0:0]   RST_SENS = `TSC_RST_SENSOR_CTRL;
	localparam [3:0]   OFS_REF  = `TSC_OFS_REF_AMP_EN;
	localparam [3:0]   OFS_SENS = `TSC_OFS_SENSOR_CTRL;
	localparam [2:0]   ADC_CHAN = `TSC_ADC_CHANNEL;
	localparam integer BIT_BG   = `TSC_BIT_BANDGAP_ON;
	localparam integer BIT_AMP  = `TSC_BIT_AMPLIFIER_ON;
	localparam integer BIT_SEN  = `TSC_BIT_SENSOR_ON;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	wire        req;
	wire        hit_ref;
	wire        hit_sens;
	wire        wr_lane0;
	wire        rd_req;
	wire        sens_ready;
	wire        ref_ready;

	assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign hit_ref  = (wb_adr_i == OFS_REF);
	assign hit_sens = (wb_adr_i == OFS_SENS);
	assign wr_lane0 = req & wb_we_i & wb_sel_i[0];
	assign rd_req   = req & ~wb_we_i;

	// ----------------------------------------
	// next values
	// ----------------------------------------
	reg         bandgap_on_d;
	reg         amplifier_on_d;
	reg         sensor_on_d;
	reg         ack_d;
	reg  [31:0] dat_d;
	reg         sensor_valid_d;
	reg         ref_settled_d;

	// reference enable register
	always @*
	begin
		bandgap_on_d   = bandgap_on_o;
		amplifier_on_d = amplifier_on_o;
		if (wr_lane0 && hit_ref)
		begin
			bandgap_on_d   = wb_dat_i[BIT_BG];
			amplifier_on_d = wb_dat_i[BIT_AMP];
		end
	end

	// sensor control register
	always @*
	begin
		sensor_on_d = sensor_on_o;
		if (wr_lane0 && hit_sens)
		begin
			sensor_on_d = wb_dat_i[BIT_SEN];
		end
	end

	// one-cycle acknowledge
	always @*
	begin
		ack_d = req;
	end

	// read data, zero outside a read answer
	always @*
	begin
		dat_d = 32'h0000_0000;
		if (rd_req && hit_ref)
		begin
			dat_d[BIT_BG]  = bandgap_on_o;
			dat_d[BIT_AMP] = amplifier_on_o;
		end
		if (rd_req && hit_sens)
		begin
			dat_d[BIT_SEN] = sensor_on_o;
		end
	end

	// settle status
	always @*
	begin
		sensor_valid_d = sens_ready & sensor_on_o;
		ref_settled_d  = ref_ready & bandgap_on_o;
	end

	// ----------------------------------------
	// enable registers
	// ----------------------------------------
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			bandgap_on_o   <= RST_REF[BIT_BG];
			amplifier_on_o <= RST_REF[BIT_AMP];
			sensor_on_o    <= RST_SENS[0];
		end
		else
		begin
			bandgap_on_o   <= bandgap_on_d;
			amplifier_on_o <= amplifier_on_d;
			sensor_on_o    <= sensor_on_d;
		end
	end

	// ----------------------------------------
	// bus answer
	// ----------------------------------------
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= ack_d;
			wb_dat_o <= dat_d;
		end
	end

	// ----------------------------------------
	// status outputs
	// ----------------------------------------
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sensor_valid_o <= 1'b0;
			ref_settled_o  <= 1'b0;
			adc_channel_o  <= ADC_CHAN;
		end
		else
		begin
			sensor_valid_o <= sensor_valid_d;
			ref_settled_o  <= ref_settled_d;
			adc_channel_o  <= ADC_CHAN;
		end
	end

	// ----------------------------------------
	// settle timers
	// ----------------------------------------
	tsc_settle_timer #(
		.W     (8),
		.COUNT (SETTLE_CYC)
	) u_sens_timer (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.enable_i (sensor_on_o),
		.ready_o  (sens_ready)
	);

	tsc_settle_timer #(
		.W     (16),
		.COUNT (REF_SETTLE_CYC)
	) u_ref_timer (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.enable_i (bandgap_on_o),
		.ready_o  (ref_ready)
	);
endmodule // tsc_top

// *** inc/tsc_consts.vh ***
// constants for the temperature sensor enable control block
// assumes a 32-bit classic wishbone slave with byte addresses
`ifndef TSC_CONSTS_VH
`define TSC_CONSTS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define TSC_OFS_REF_AMP_EN    4'h0
`define TSC_OFS_SENSOR_CTRL   4'h4

// ----------------------------------------
// field positions
// ----------------------------------------
`define TSC_BIT_BANDGAP_ON    0
`define TSC_BIT_AMPLIFIER_ON  1
`define TSC_BIT_SENSOR_ON     0

// ----------------------------------------
// reset values
// ----------------------------------------
`define TSC_RST_REF_AMP_EN    2'h0
`define TSC_RST_SENSOR_CTRL   1'h0

// ----------------------------------------
// timing
// ----------------------------------------
`define TSC_CLK_MHZ           10
`define TSC_SETTLE_US         10
`define TSC_SETTLE_CYC        (`TSC_SETTLE_US * `TSC_CLK_MHZ)
`define TSC_REF_SETTLE_US     1000
`define TSC_REF_SETTLE_CYC    (`TSC_REF_SETTLE_US * `TSC_CLK_MHZ)

// ----------------------------------------
// converter routing
// ----------------------------------------
`define TSC_ADC_CHANNEL       3'h2

`endif

// *** hdl/tsc_settle_timer.v ***
// settle timer: counts cycles after an enable rises, then flags ready
// assumes enable_i comes from logic on clk_i
`timescale 1ns/1ps
module tsc_settle_timer #(
	parameter W     = 16,
	parameter COUNT = 100
) (
	input  wire clk_i,
	input  wire rst_i,
	input  wire enable_i,
	output reg  ready_o
);
	localparam integer LAST = COUNT - 1;

	reg [W-1:0] cnt_q;

	always @(posedge clk_i)
	begin
		if (rst_i || !enable_i)
		begin
			cnt_q   <= {W{1'b0}};
			ready_o <= 1'b0;
		end
		else if ({{(32-W){1'b0}}, cnt_q} < LAST)
		begin
			cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
		end
		else
		begin
			ready_o <= 1'b1;
		end
	end
endmodule // tsc_settle_timer

// *** dv/tsc_top_properties.sv ***
// checker for tsc_top bus answers and enable outputs
// assumes tsc_top built with SETTLE_CYC of 4
`timescale 1ns/1ps
module tsc_chk (
	input wire        clk_i,
	input wire        rst_i,
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire        wb_we_i,
	input wire        wb_ack_o,
	input wire [3:0]  wb_adr_i,
	input wire [3:0]  wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire        bandgap_on_o,
	input wire        amplifier_on_o,
	input wire        sensor_on_o,
	input wire        sensor_valid_o,
	input wire [2:0]  adc_channel_o
);
	wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wr = req & wb_we_i & wb_sel_i[0];
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	AST_ACK: assert property (req |=> wb_ack_o ##1 !wb_ack_o) else $error("ack");
	AST_BGAP: assert property (wr && wb_adr_i == 4'h0 |=> bandgap_on_o == $past(wb_dat_i[0]))
		else $error("bandgap");
	AST_AMP: assert property (wr && wb_adr_i == 4'h0 |=> amplifier_on_o == $past(wb_dat_i[1]))
		else $error("amp");
	AST_SENS: assert property (wr && wb_adr_i == 4'h4 |=> sensor_on_o == $past(wb_dat_i[0]))
		else $error("sensor");
	AST_KEEP: assert property (!(wr && wb_adr_i == 4'h0) |=> $stable({bandgap_on_o, amplifier_on_o}))
		else $error("keep");
	AST_RSVD: assert property (wb_ack_o |-> wb_dat_o[31:2] == 30'h0) else $error("rsvd");
	AST_VALID: assert property ($rose(sensor_on_o) |-> !sensor_valid_o [*5])
		else $error("valid");
	AST_VOFF: assert property (!sensor_on_o |=> !sensor_valid_o) else $error("valid off");
	AST_CHAN: assert property (adc_channel_o == 3'h2) else $error("chan");
endmodule // tsc_chk
bind tsc_top tsc_chk chk (.*);

// *** dv/tsc_top_test.sv ***
// random register traffic bench for tsc_top
// assumes the bound checker and a 10 MHz clock
`timescale 1ns/1ps
module tsc_top_test;
	reg clk_i = 0, rst_i = 1, cyc = 0, we = 0;
	reg [3:0] adr = 0, sel = 0, a, s;
	reg [31:0] dat = 0, r, d, e0 = 0, e4 = 0;
	wire [31:0] dato;
	wire ack, bg, reference_amplifier, son, sval, rset;
	wire [2:0] ch;
	integer fail_count = 0, tests_run = 0, n = 0, i;
	tsc_top #(.SETTLE_CYC(4), .REF_SETTLE_CYC(8)) dut (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(dato), .wb_ack_o(ack), .bandgap_on_o(bg),
		.amplifier_on_o(reference_amplifier), .sensor_on_o(son), .sensor_valid_o(sval),
		.ref_settled_o(rset), .adc_channel_o(ch));
	initial forever #50 clk_i = ~clk_i;
	always @(posedge clk_i) if (++n > 3000)
	begin
		fail_count++;
		print_verdict;
	end
	function [31:0] exp_rd(input [3:0] x);
		exp_rd = (x == 4'h0) ? e0 : ((x == 4'h4) ? e4 : 32'h0);
	endfunction
	task check(input [31:0] seen, exp);
		tests_run++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("MISMATCH %0t got %h exp %h", $time, seen, exp);
		end
	endtask
	task bus(input w, input [3:0] x, input [31:0] v, input [3:0] m);
		cyc <= 1'b1;
		we <= w;
		adr <= x;
		dat <= v;
		sel <= m;
		do @(posedge clk_i); while (ack !== 1'b1);
		r = dato;
		cyc <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		void'($urandom(63));
		repeat (3) @(posedge clk_i);
		rst_i <= 0;
		bus(0, 0, 0, 15);
		check(r, 0);
		bus(0, 4, 0, 15);
		check(r, 0);
		check(ch, 2);
		for (i = 0; i < 40; i++)
		begin
			a = ($urandom % 3) * 4;
			d = $urandom;
			s = $urandom;
			// external reference never selected here
			if (a == 4'h0)
				d[1] = d[1] | d[0];
			if (a == 4'h0 && e4[0])
				d[1:0] = 2'h3;
			if (a == 4'h4 && d[0])
			begin
				d[0] = e0[0];
				repeat (10) @(posedge clk_i);
			end
			bus(1, a, d, s);
			if (s[0] && a == 4'h0)
				e0 = d & 32'h3;
			if (s[0] && a == 4'h4)
				e4 = d & 32'h1;
			bus(0, a, 0, 15);
			check(r, exp_rd(a));
			check({son, reference_amplifier, bg}, {e4[0], e0[1:0]});
		end
		bus(1, 4, 0, 1);
		check(sval, 0);
		bus(1, 0, 3, 1);
		repeat (10) @(posedge clk_i);
		bus(1, 4, 1, 1);
		check(sval, 0);
		repeat (6) @(posedge clk_i);
		check({rset, sval}, 3);
		print_verdict;
	end
endmodule // tsc_top_test
